/* hw/i2c_slave_core_select_port.v */
// two-wire slave host port routing register writes and reads to four decoder cores
// What this block does
// - answer bus address 10111 followed by the two select pin levels
// - catch select pins after reset release, keep address until next reset
// - slave only: never start, never drive clock as master
// - handle bit rates up to 400 kbit/s
// - change data only while clock low, stable while high
// - data fall with clock high is start, data rise is stop
// - eight-bit bytes, msb first, each followed by acknowledge, any count
// - write: start, address dir 0, sub-address, data, each acked, stop
// - sub-address names first register of a written block
// - read: address dir 1, then data from previous sub-address
// - write-select bits pick which cores receive writes
// - read-select bits pick which core answers reads
// - several read-select bits set: lowest-numbered core serves
// - writing either select register clears the other to zero
// - hold clock low while the core needs time
`timescale 1ns/1ps
`include "i2c_port_defs.vh"
module i2c_slave_core_select_port (
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  input  wire       scl_i,
  output wire       scl_o,
  output wire       scl_oe_o,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  input  wire       addr_select_pin0_i,
  input  wire       addr_select_pin1_i,
  output reg  [3:0] core_wr_en_o,
  output reg  [7:0] core_addr_o,
  output reg  [7:0] core_wdata_o,
  output reg  [3:0] core_rd_en_o,
  input  wire [7:0] core0_rdata_i,
  input  wire [7:0] core1_rdata_i,
  input  wire [7:0] core2_rdata_i,
  input  wire [7:0] core3_rdata_i,
  input  wire       core_busy_i,
  output wire [3:0] write_select_o,
  output wire [3:0] read_select_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_SUB  = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_RDAT = 3'h4;
  localparam ST_MACK = 3'h5;

  wire scl_s, scl_rise, scl_fall;
  wire sda_s, sda_rise, sda_fall;
  wire start_det, stop_det;

  reg  [2:0] state_r;
  reg  [2:0] bit_r;
  reg  [7:0] shift_r;
  reg        ack_phase_r;
  reg        ack_drive_r;
  reg        rd_drive_r;
  reg        rd_bit_r;
  reg  [7:0] ptr_r;
  reg  [7:0] rdata_r;
  reg  [3:0] wr_sel_r;
  reg  [3:0] rd_sel_r;
  reg  [6:0] dev_addr_r;
  reg        strap_done_r;
  reg  [1:0] pin_meta_r;
  reg  [1:0] pin_sync_r;
  reg        stretch_r;
  reg  [1:0] strap_cnt_r;
  reg        skip_fall_r;

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  bus_line_sync scl_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .line_i    (scl_i), // 8+ clocks per phase even at 400 kbit/s
    .level_o   (scl_s),
    .rise_o    (scl_rise),
    .fall_o    (scl_fall)
  );

  bus_line_sync sda_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .line_i    (sda_i),
    .level_o   (sda_s),
    .rise_o    (sda_rise),
    .fall_o    (sda_fall)
  );

  // conditions on data while clock high
  assign start_det = sda_fall & scl_s;
  assign stop_det  = sda_rise & scl_s;

  // ****************************************************************
  // address strap
  // ****************************************************************
  // strap pins synchronised; caught once both flops hold real pin levels
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_r   <= 2'h0;
      pin_sync_r   <= 2'h0;
      strap_done_r <= 1'b0;
      strap_cnt_r  <= 2'h0;
      dev_addr_r   <= 7'h00;
    end else begin
      pin_meta_r <= {addr_select_pin1_i, addr_select_pin0_i};
      pin_sync_r <= pin_meta_r;
      if (!strap_done_r) begin
        if (strap_cnt_r == `STRAP_SETTLE) begin
          strap_done_r <= 1'b1; // held until the next reset
          dev_addr_r   <= {`ADDR_PREFIX, pin_sync_r};
        end else begin
          strap_cnt_r <= strap_cnt_r + 2'h1;
        end
      end
    end
  end

  // ****************************************************************
  // read data choice
  // ****************************************************************
  // lowest set bit wins so a careless multi-bit select still yields one core
  function [7:0] pick_rdata;
    input [3:0] sel;
    input [7:0] d0;
    input [7:0] d1;
    input [7:0] d2;
    input [7:0] d3;
    begin
      if (sel[0])      pick_rdata = d0;
      else if (sel[1]) pick_rdata = d1;
      else if (sel[2]) pick_rdata = d2;
      else if (sel[3]) pick_rdata = d3;
      else             pick_rdata = 8'h00;
    end
  endfunction

  function [3:0] lowest_bit;
    input [3:0] sel;
    begin
      lowest_bit = sel & (~sel + 4'h1);
    end
  endfunction

  // global selects read back from this port, not from a core
  always @* begin
    if (ptr_r == `REG_WRITE_SEL)
      rdata_r = {4'h0, wr_sel_r};
    else if (ptr_r == `REG_READ_SEL)
      rdata_r = {4'h0, rd_sel_r};
    else
      rdata_r = pick_rdata(rd_sel_r, core0_rdata_i, core1_rdata_i,
                           core2_rdata_i, core3_rdata_i);
  end

  // ****************************************************************
  // protocol engine
  // ****************************************************************
  // sda only moves on a clock fall so it is settled before the high phase
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r      <= ST_IDLE;
      bit_r        <= `BIT_FIRST;
      shift_r      <= 8'h00;
      ack_phase_r  <= 1'b0;
      ack_drive_r  <= 1'b0;
      rd_drive_r   <= 1'b0;
      rd_bit_r     <= 1'b1;
      ptr_r        <= 8'h00;
      wr_sel_r     <= `SEL_RESET;
      rd_sel_r     <= `SEL_RESET;
      core_wr_en_o <= 4'h0;
      core_rd_en_o <= 4'h0;
      core_addr_o  <= 8'h00;
      core_wdata_o <= 8'h00;
      stretch_r    <= 1'b0;
      skip_fall_r  <= 1'b0;
    end else begin
      core_wr_en_o <= 4'h0;
      core_rd_en_o <= 4'h0;
      core_addr_o  <= ptr_r; // cores see the pointer so read data is ready
      // hold clock low after a byte while any core is still digesting
      if (stretch_r && !core_busy_i)
        stretch_r <= 1'b0;
      if (start_det) begin
        state_r     <= ST_ADDR; // repeated start allowed
        skip_fall_r <= 1'b1;
        bit_r       <= `BIT_FIRST;
        ack_phase_r <= 1'b0;
        ack_drive_r <= 1'b0;
        rd_drive_r  <= 1'b0;
      end else if (stop_det) begin
        state_r     <= ST_IDLE;
        ack_drive_r <= 1'b0;
        rd_drive_r  <= 1'b0;
        stretch_r   <= 1'b0;
      end else if (state_r != ST_IDLE && scl_rise) begin
        if (!ack_phase_r && state_r != ST_RDAT) begin
          shift_r <= {shift_r[6:0], sda_s}; // msb first
        end else if (ack_phase_r && state_r == ST_MACK) begin
          // master nack ends the read burst
          state_r <= sda_s ? ST_IDLE : ST_RDAT;
        end
      end else if (state_r != ST_IDLE && scl_fall) begin
        if (skip_fall_r) begin
          skip_fall_r <= 1'b0; // fall closing a start carries no bit
        end else if (ack_phase_r) begin
          // master clocked the ack; release and start next byte
          ack_phase_r <= 1'b0;
          ack_drive_r <= 1'b0;
          bit_r       <= `BIT_FIRST;
          if (state_r == ST_RDAT) begin
            rd_drive_r <= 1'b1;
            rd_bit_r   <= rdata_r[7];
            shift_r    <= {rdata_r[6:0], 1'b0};
            core_addr_o <= ptr_r;
            core_rd_en_o <= lowest_bit(rd_sel_r);
            ptr_r      <= ptr_r + 8'h01;
          end else if (state_r == ST_MACK) begin
            state_r <= ST_IDLE;
          end
        end else if (state_r == ST_RDAT) begin
          if (bit_r == `BIT_LAST) begin
            rd_drive_r  <= 1'b0;
            ack_phase_r <= 1'b1;
            state_r     <= ST_MACK;
          end else begin
            bit_r    <= bit_r + 3'h1;
            rd_bit_r <= shift_r[7];
            shift_r  <= {shift_r[6:0], 1'b0};
          end
        end else if (bit_r == `BIT_LAST) begin
          ack_phase_r <= 1'b1;
          case (state_r)
            ST_ADDR: begin
              if (shift_r[7:1] == dev_addr_r) begin
                ack_drive_r <= 1'b1;
                state_r     <= (shift_r[0] == `DIR_READ) ? ST_RDAT : ST_SUB;
              end else begin
                state_r     <= ST_IDLE;
                ack_phase_r <= 1'b0;
              end
            end
            ST_SUB: begin
              ack_drive_r <= 1'b1;
              ptr_r       <= shift_r;
              state_r     <= ST_WDAT;
            end
            ST_WDAT: begin
              ack_drive_r <= 1'b1;
              ptr_r       <= ptr_r + 8'h01;
              if (ptr_r == `REG_WRITE_SEL) begin
                wr_sel_r <= shift_r[3:0];
                rd_sel_r <= `SEL_CLEAR;
              end else if (ptr_r == `REG_READ_SEL) begin
                rd_sel_r <= shift_r[3:0];
                wr_sel_r <= `SEL_CLEAR;
              end else begin
                core_addr_o  <= ptr_r;
                core_wdata_o <= shift_r;
                core_wr_en_o <= wr_sel_r; // parallel write
                stretch_r    <= |wr_sel_r; // no selected core, nobody to wait
              end
            end
            default: begin
              state_r <= ST_IDLE;
            end
          endcase
        end else begin
          bit_r <= bit_r + 3'h1;
        end
      end
    end
  end

  // ****************************************************************
  // open-drain pins
  // ****************************************************************
  // only ever pulls low; no start generation, clock only for stretch
  assign scl_o    = 1'b0;
  assign scl_oe_o = stretch_r & ~scl_s;
  assign sda_o    = 1'b0;
  assign sda_oe_o = ack_drive_r | (rd_drive_r & ~rd_bit_r);

  assign write_select_o = wr_sel_r;
  assign read_select_o  = rd_sel_r;
endmodule

/* hw/i2c_port_defs.vh */
// constants for the two-wire host port of the four-core decoder
`ifndef I2C_PORT_DEFS_VH
`define I2C_PORT_DEFS_VH
`define ADDR_PREFIX      5'h17
`define DIR_WRITE        1'b0
`define DIR_READ         1'b1
`define REG_WRITE_SEL    8'hFE
`define REG_READ_SEL     8'hFF
`define SEL_CLEAR        4'h0
`define SEL_RESET        4'h0
`define CORE_SEL_W       4
`define BIT_LAST         3'h7
`define BIT_FIRST        3'h0
`define STRETCH_MAX      8'hFF
`define STRAP_SETTLE     2'h2
`endif

/* hw/bus_line_sync.v */
// two-flop synchroniser with edge detection for the serial clock and data pins
`timescale 1ns/1ps
module bus_line_sync (
  input  wire ref_clk_i,
  input  wire rstn_i,
  input  wire line_i,
  output reg  level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_r;
  reg prev_r;

  // first flop feeds only the second; bus idles high so reset to one
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r  <= 1'b1;
      level_o <= 1'b1;
      prev_r  <= 1'b1;
    end else begin
      meta_r  <= line_i;
      level_o <= meta_r;
      prev_r  <= level_o;
    end
  end

  assign rise_o = level_o & ~prev_r;
  assign fall_o = ~level_o & prev_r;
endmodule

/* tb/i2c_port_checker_assertions.sv */
// concurrent checks on the ports of the two-wire host port
`timescale 1ns/1ps
module i2c_port_checker (
  input logic       ref_clk_i,
  input logic       rstn_i,
  input logic       scl_i,
  input logic       scl_o,
  input logic       scl_oe_o,
  input logic       sda_o,
  input logic       sda_oe_o,
  input logic [3:0] core_wr_en_o,
  input logic [7:0] core_addr_o,
  input logic [3:0] core_rd_en_o,
  input logic       core_busy_i,
  input logic [3:0] write_select_o,
  input logic [3:0] read_select_o
);
  // ****************
  // port properties
  // ****************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // raw scl is used: the port reacts 2-3 clocks late, so scl is still low then
  property p_pull; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_pull: assert property (p_pull) else $error("pin value not low");
  property p_still; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_still: assert property (p_still) else $error("data moved with clock high");
  property p_hold; $rose(scl_oe_o) |-> core_busy_i || $past(core_busy_i); endproperty
  a_hold: assert property (p_hold) else $error("clock held without busy core");
  property p_free; scl_oe_o && !core_busy_i |-> ##[0:3] !scl_oe_o; endproperty
  a_free: assert property (p_free) else $error("clock held after busy fell");
  property p_wr; |core_wr_en_o |-> core_wr_en_o == write_select_o && core_addr_o < 8'hFE;
  endproperty
  a_wr: assert property (p_wr) else $error("core write misrouted");
  property p_wone; |core_wr_en_o |=> core_wr_en_o == 4'h0; endproperty
  a_wone: assert property (p_wone) else $error("write strobe too long");
  property p_rd; |core_rd_en_o |-> core_rd_en_o == (read_select_o & (~read_select_o + 4'h1));
  endproperty
  a_rd: assert property (p_rd) else $error("read not from lowest core");
  property p_excl; write_select_o == 4'h0 || read_select_o == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("both selects set");
endmodule
bind i2c_slave_core_select_port i2c_port_checker chk (.ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .core_wr_en_o(core_wr_en_o), .core_addr_o(core_addr_o),
  .core_rd_en_o(core_rd_en_o), .core_busy_i(core_busy_i),
  .write_select_o(write_select_o), .read_select_o(read_select_o));

/* tb/i2c_master_model.sv */
// bus master model driving the host port, 160 ns bit time
`timescale 1ns/1ps
module i2c_master_model (
  input  wire       clk_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        scl_low_o  = 1'b0,
  output reg        sda_low_o  = 1'b0,
  output reg  [7:0] timeouts_o = 8'h00
);
  // ****************
  // bus primitives
  // ****************
  integer k;
  task qtr;
    repeat (2) @(negedge clk_i);
  endtask
  // release clock, wait out a stretch under a bound so a stuck port cannot hang us
  // watching the stretch replaces the fixed 128 us gap between transactions
  task rise;
    begin
      scl_low_o = 1'b0;
      for (k = 0; k < 500 && scl_i !== 1'b1; k = k + 1) @(negedge clk_i);
      if (scl_i !== 1'b1) timeouts_o = timeouts_o + 8'h01;
      qtr;
      qtr; // 80 ns high and 80 ns low give the 160 ns bit
    end
  endtask
  task bit_io(input b, output r);
    begin
      sda_low_o = !b;
      qtr;
      rise;
      r = sda_i;
      scl_low_o = 1'b1;
      qtr;
    end
  endtask
  task start;
    begin
      sda_low_o = 1'b0;
      qtr;
      rise;
      sda_low_o = 1'b1;
      qtr;
      scl_low_o = 1'b1;
      qtr;
    end
  endtask
  task stop;
    begin
      sda_low_o = 1'b1;
      qtr;
      rise;
      sda_low_o = 1'b0;
      qtr;
    end
  endtask
  // eight bits msb first, then the acknowledge slot at level a
  task xfer(input [7:0] d, input a, output [7:0] r, output ra);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r[i]);
      bit_io(a, ra);
    end
  endtask
endmodule

/* tb/i2c_slave_core_select_port_tb_top.sv */
// self-checking bench for the two-wire host port
`timescale 1ns/1ps
module i2c_slave_core_select_port_tb_top;
  // ****************
  // bench
  // ****************
  localparam [6:0] dev_addr = 7'h5E;
  reg         ref_clk_i = 1'b0;
  reg         rstn_i    = 1'b0;
  reg  [1:0]  pins      = 2'b10;
  reg  [5:0]  bcnt      = 6'h00;
  reg  [19:0] wr_log    = 20'h00000;
  wire        scl, sda, m_scl, m_sda, scl_oe, sda_oe;
  wire [3:0]  wr_en, wsel, rsel;
  wire [7:0]  addr, wdata;
  integer     n_wr = 0, n_errors = 0, checks_done = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  // wired-and bus lines with pull-ups
  assign scl = ~(m_scl | scl_oe);
  assign sda = ~(m_sda | sda_oe);
  // cores stay busy a while after each write so the port has to stretch
  always @(negedge ref_clk_i) bcnt <= (|wr_en) ? 6'h1E : bcnt - {5'h00, |bcnt};
  always @(posedge ref_clk_i) if (|wr_en) begin
    wr_log <= {wr_en, addr, wdata};
    n_wr <= n_wr + 1;
  end
  i2c_slave_core_select_port uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl),
    .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .addr_select_pin0_i(pins[0]), .addr_select_pin1_i(pins[1]), .core_wr_en_o(wr_en),
    .core_addr_o(addr), .core_wdata_o(wdata), .core_rd_en_o(),
    .core0_rdata_i(addr ^ 8'h10), .core1_rdata_i(addr ^ 8'h20),
    .core2_rdata_i(addr ^ 8'h40), .core3_rdata_i(addr ^ 8'h80),
    .core_busy_i(bcnt != 6'h00), .write_select_o(wsel), .read_select_o(rsel));
  i2c_master_model m (.clk_i(ref_clk_i), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
    .sda_low_o(m_sda), .timeouts_o());
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task send(input [7:0] d, input a);
    reg [7:0] r;
    reg       k;
    begin
      m.xfer(d, 1'b1, r, k);
      chk({7'h00, k}, {7'h00, a});
    end
  endtask
  task wr(input [6:0] dv, input [7:0] sub, input [7:0] d, input integer n);
    integer i;
    begin
      m.start;
      send({dv, 1'b0}, 1'b0);
      send(sub, 1'b0);
      for (i = 0; i < n; i = i + 1) send(d + i[7:0], 1'b0);
      m.stop;
    end
  endtask
  task rd(input [7:0] sub, input [7:0] e, input integer n);
    integer i;
    reg [7:0] r;
    reg       k;
    begin
      wr(dev_addr, sub, 8'h00, 0);
      m.start;
      send({dev_addr, 1'b1}, 1'b0);
      for (i = 0; i < n; i = i + 1) begin
        m.xfer(8'hFF, i == n - 1, r, k);
        chk(r, e + i[7:0]);
      end
      m.stop;
    end
  endtask
  task end_sim;
    begin
      $display("writes=%0d checks=%0d errors=%0d", n_wr, checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    pins = 2'b01; // straps move after capture; address must not follow them
    repeat (4) @(negedge ref_clk_i);
    m.start;
    send({7'h5D, 1'b0}, 1'b1);
    m.stop;
    wr(dev_addr, 8'hFE, 8'h05, 1);
    chk({wsel, rsel}, 8'h50);
    wr(dev_addr, 8'h10, 8'hA1, 2);
    chk({4'h0, wr_log[19:16]}, 8'h05);
    chk(wr_log[15:8], 8'h11);
    chk(wr_log[7:0], 8'hA2);
    wr(dev_addr, 8'hFF, 8'h06, 1);
    chk({wsel, rsel}, 8'h06);
    rd(8'h22, 8'h02, 2);
    rd(8'hFF, 8'h06, 1);
    wr(dev_addr, 8'h30, 8'h77, 1);
    chk(n_wr[7:0], 8'h02);
    wr(dev_addr, 8'hFE, 8'h03, 1);
    chk({wsel, rsel}, 8'h30);
    chk(m.timeouts_o, 8'h00);
    end_sim;
  end
endmodule
